//--- rtl/icwc_consts.svh
// Constants of the idle clock and wake control block.
// Assumes a 100 MHz core clock; included by the package, the top module and the testbench.
`ifndef ICWC_CONSTS_SVH
`define ICWC_CONSTS_SVH

`define ICWC_CLK_MHZ        100
`define ICWC_CAL_LIMIT_MS   2000
`define ICWC_CAL_CYCLES     (`ICWC_CAL_LIMIT_MS * 1000 * `ICWC_CLK_MHZ)
`define ICWC_CAL_CNT_W      28
`define ICWC_GAIN_W         16
`define ICWC_OFS_W          16
`define ICWC_BW_W           2
`define ICWC_GAIN_THR1      16'h0064
`define ICWC_GAIN_THR2      16'h03e8
`define ICWC_GAIN_THR3      16'h2710
`define ICWC_DEV_ERR_NONE   8'h00
`define ICWC_DEV_ERR_CAL    8'h01
`define ICWC_ADDR_W         4
`define ICWC_REG_CTRL       4'h0
`define ICWC_REG_STATUS     4'h1
`define ICWC_REG_IRQ_STAT   4'h2
`define ICWC_REG_IRQ_MASK   4'h3
`define ICWC_REG_BW         4'h4
`define ICWC_REG_DEV_ERR    4'h5
`define ICWC_CTRL_AWAKE_BIT 0
`define ICWC_CTRL_CAL_BIT   1
`define ICWC_CTRL_BW_BIT    2
`define ICWC_IRQ_W          4
`define ICWC_IRQ_WAKE       0
`define ICWC_IRQ_CAL_DONE   1
`define ICWC_IRQ_CAL_FAIL   2
`define ICWC_IRQ_OVLD       3

`endif

//--- rtl/icwc_pkg.sv
// Types of the idle clock and wake control block.
// Assumes the constants header sits beside it.
`include "icwc_consts.svh"

package icwc_pkg;

   typedef enum logic [1:0] {
      ICWC_IDLE = 2'b00,
      ICWC_RUN  = 2'b01,
      ICWC_CAL  = 2'b11,
      ICWC_DONE = 2'b10
   } icwc_state_e;

   typedef struct packed {
      logic [`ICWC_GAIN_W-1:0] gain;
      logic [`ICWC_OFS_W-1:0]  offset;
   } icwc_setting_s;

   typedef struct packed {
      logic button;
      logic cal_buttons;
      logic link_active;
      logic reply_busy;
      logic adjust_busy;
      logic overload;
   } icwc_wake_s;

endpackage : icwc_pkg

//--- rtl/icwc_save_mem.sv
// Small store that keeps the setting saved before calibration.
// Assumes writes and reads on the single core clock; read data registered.
`timescale 1ns/100ps

module icwc_save_mem
   import icwc_pkg::*;
(
   // Clock and reset.
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // Write side.
   input  wire logic          wr_en,
   input  wire icwc_setting_s wr_data,
   // Read side.
   output icwc_setting_s      rd_data
);

   icwc_setting_s store_reg;
   icwc_setting_s store_next;
   icwc_setting_s rd_reg;

   always_comb begin
      store_next = wr_en ? wr_data : store_reg;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         store_reg <= '0;
         rd_reg    <= '0;
      end else begin
         store_reg <= store_next;
         rd_reg    <= store_reg;
      end
   end

   assign rd_data = rd_reg;

endmodule : icwc_save_mem

//--- rtl/icwc_top.sv
// Idle clock and wake control: clock gating, calibration sequencing,
// bandwidth default and override, and a small register port.
// Assumes all inputs synchronous to core_clk; the calibration engine
// reports done or fail by pulses; settings are applied by the caller.
// Operation
// R01: Halt clock when no work is pending.
// R02: Wake on power-on, button, link, overload.
// R03: Run until adjustment or reply finishes.
// R04: Keep clock on throughout an overload.
// R05: Keep-awake setting prevents any clock stop.
// R06: Keep-awake clears to off at power-on.
// R07: Calibrate on command or button combination.
// R08: Calibration ends within two seconds.
// R09: Restore gain and offset after calibration.
// R10: Failed calibration records device error one.
// R11: Host may override bandwidth setting.
// R12: Button press restores default bandwidth.
// R13: Power cycle or calibration restores default bandwidth.
// R14: Four bandwidth settings from gain magnitude ranges.
// R15: One merged wake request gates the clock.
`timescale 1ns/100ps
`include "icwc_consts.svh"

module icwc_top
   import icwc_pkg::*;
(
   // Clock and reset.
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   // Wake sources, task status and current setting.
   input  wire icwc_wake_s              wake_in,
   input  wire icwc_setting_s           setting_in,
   // Calibration engine.
   input  wire logic                    cal_done,
   input  wire logic                    cal_fail,
   output logic                         cal_run,
   output logic                         cal_params_revert,
   // Setting restore and bandwidth.
   output logic                         setting_restore,
   output icwc_setting_s                setting_out,
   output logic [`ICWC_BW_W-1:0]        bw_sel,
   // Clock gating.
   output logic                         clk_enable,
   // Register port.
   input  wire logic [`ICWC_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [31:0]                  reg_rdata,
   // Interrupt.
   output logic                         irq
);

   function automatic logic [`ICWC_BW_W-1:0] bw_for_gain(
      input logic [`ICWC_GAIN_W-1:0] g);
      logic [`ICWC_GAIN_W-1:0] mag;
      mag = g[`ICWC_GAIN_W-1] ? (~g + 16'h0001) : g;
      if (mag < `ICWC_GAIN_THR1)
         bw_for_gain = 2'h0;
      else if (mag < `ICWC_GAIN_THR2)
         bw_for_gain = 2'h1;
      else if (mag < `ICWC_GAIN_THR3)
         bw_for_gain = 2'h2;
      else
         bw_for_gain = 2'h3;
   endfunction : bw_for_gain

   function automatic logic wr_hit(input logic [`ICWC_ADDR_W-1:0] a);
      wr_hit = reg_wr && (reg_addr == a);
   endfunction : wr_hit

   icwc_state_e                 state_reg;
   icwc_state_e                 state_next;
   logic [`ICWC_CAL_CNT_W-1:0]  cal_cnt_reg;
   logic [`ICWC_CAL_CNT_W-1:0]  cal_cnt_next;
   logic                        awake_reg;
   logic                        awake_next;
   logic                        bw_ovr_reg;
   logic                        bw_ovr_next;
   logic [`ICWC_BW_W-1:0]       bw_val_reg;
   logic [`ICWC_BW_W-1:0]       bw_val_next;
   logic [7:0]                  dev_err_reg;
   logic [7:0]                  dev_err_next;
   logic [`ICWC_IRQ_W-1:0]      irq_stat_reg;
   logic [`ICWC_IRQ_W-1:0]      irq_stat_next;
   logic [`ICWC_IRQ_W-1:0]      irq_mask_reg;
   logic [`ICWC_IRQ_W-1:0]      irq_mask_next;
   logic                        pwr_wake_reg;
   logic                        restore_reg;
   logic                        restore_next;
   logic                        revert_reg;
   logic                        revert_next;
   logic [31:0]                 rdata_reg;
   logic [31:0]                 rdata_next;
   logic                        cal_cmd;
   logic                        cal_start;
   logic                        cal_end;
   logic                        cal_timeout;
   logic                        busy;
   logic                        wake_evt;
   logic [`ICWC_IRQ_W-1:0]      events;
   icwc_setting_s               saved;

   // The saved setting is taken on the cycle calibration starts.
   icwc_save_mem u_save (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_en    (cal_start),
      .wr_data  (setting_in),
      .rd_data  (saved)
   );

   assign cal_cmd = wr_hit(`ICWC_REG_CTRL) &&
                    reg_wdata[`ICWC_CTRL_CAL_BIT];
   assign cal_start = (state_reg != ICWC_CAL) &&
                      (cal_cmd || wake_in.cal_buttons); // R07
   // A timeout counts as failure so the module never hangs.
   assign cal_timeout = (cal_cnt_reg == `ICWC_CAL_CNT_W'(`ICWC_CAL_CYCLES - 1));
   assign cal_end = (state_reg == ICWC_CAL) &&
                    (cal_done || cal_fail || cal_timeout); // R08
   assign wake_evt = wake_in.button || wake_in.link_active ||
                     wake_in.overload || pwr_wake_reg; // R02
   assign busy = wake_evt || wake_in.reply_busy ||
                 wake_in.adjust_busy || cal_start; // R03 R04

   // Sequencer state.
   always_comb begin
      state_next   = state_reg;
      cal_cnt_next = '0;
      case (state_reg)
         ICWC_IDLE: begin
            if (cal_start)
               state_next = ICWC_CAL;
            else if (busy)
               state_next = ICWC_RUN;
         end
         ICWC_RUN: begin
            if (cal_start)
               state_next = ICWC_CAL;
            else if (!busy)
               state_next = ICWC_IDLE; // R01
         end
         ICWC_CAL: begin
            cal_cnt_next = cal_cnt_reg + `ICWC_CAL_CNT_W'(1);
            if (cal_end)
               state_next = ICWC_DONE;
         end
         ICWC_DONE: begin
            // A start request here must not be lost between two runs.
            if (cal_start)
               state_next = ICWC_CAL; // R07
            else
               state_next = ICWC_RUN;
         end
         default: begin
            state_next = ICWC_IDLE;
         end
      endcase
   end

   // Settings, bandwidth, errors and restore pulses.
   always_comb begin
      awake_next   = awake_reg;
      bw_ovr_next  = bw_ovr_reg;
      bw_val_next  = bw_val_reg;
      dev_err_next = dev_err_reg;
      restore_next = 1'b0;
      revert_next  = 1'b0;
      if (wr_hit(`ICWC_REG_CTRL)) begin
         awake_next = reg_wdata[`ICWC_CTRL_AWAKE_BIT];
      end
      if (wr_hit(`ICWC_REG_BW)) begin
         bw_ovr_next = 1'b1; // R11
         bw_val_next = reg_wdata[`ICWC_BW_W-1:0];
      end
      if (wake_in.button) begin
         bw_ovr_next = 1'b0; // R12
      end
      if (cal_end) begin
         restore_next = 1'b1; // R09
         bw_ovr_next  = 1'b0; // R13
         if (cal_fail || cal_timeout) begin
            revert_next  = 1'b1; // R10
            dev_err_next = `ICWC_DEV_ERR_CAL;
         end
      end
      if (reg_rd && reg_addr == `ICWC_REG_DEV_ERR) begin
         // Reading the error code clears it unless a new failure lands.
         if (!(cal_end && (cal_fail || cal_timeout)))
            dev_err_next = `ICWC_DEV_ERR_NONE;
      end
   end

   assign events = {wake_in.overload,
                    cal_end && (cal_fail || cal_timeout),
                    cal_end && cal_done && !cal_timeout,
                    wake_evt};

   // Sticky status is cleared by writing ones; a new event wins.
   always_comb begin
      irq_stat_next = irq_stat_reg;
      irq_mask_next = irq_mask_reg;
      if (wr_hit(`ICWC_REG_IRQ_STAT))
         irq_stat_next = irq_stat_reg & ~reg_wdata[`ICWC_IRQ_W-1:0];
      irq_stat_next = irq_stat_next | events;
      if (wr_hit(`ICWC_REG_IRQ_MASK))
         irq_mask_next = reg_wdata[`ICWC_IRQ_W-1:0];
   end

   // Read data appear only in the cycle after the read strobe.
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            `ICWC_REG_CTRL:
               rdata_next = {31'h0, awake_reg};
            `ICWC_REG_STATUS:
               rdata_next = {28'h0, bw_ovr_reg, clk_enable, state_reg};
            `ICWC_REG_IRQ_STAT:
               rdata_next = {28'h0, irq_stat_reg};
            `ICWC_REG_IRQ_MASK:
               rdata_next = {28'h0, irq_mask_reg};
            `ICWC_REG_BW:
               rdata_next = {30'h0, bw_sel};
            `ICWC_REG_DEV_ERR:
               rdata_next = {24'h0, dev_err_reg};
            default:
               rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ICWC_IDLE;
         cal_cnt_reg  <= '0;
         awake_reg    <= 1'b0; // R06
         bw_ovr_reg   <= 1'b0; // R13
         bw_val_reg   <= '0;
         dev_err_reg  <= `ICWC_DEV_ERR_NONE;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         pwr_wake_reg <= 1'b1;
         restore_reg  <= 1'b0;
         revert_reg   <= 1'b0;
         rdata_reg    <= 32'h0000_0000;
      end else begin
         state_reg    <= state_next;
         cal_cnt_reg  <= cal_cnt_next;
         awake_reg    <= awake_next;
         bw_ovr_reg   <= bw_ovr_next;
         bw_val_reg   <= bw_val_next;
         dev_err_reg  <= dev_err_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         pwr_wake_reg <= 1'b0;
         restore_reg  <= restore_next;
         revert_reg   <= revert_next;
         rdata_reg    <= rdata_next;
      end
   end

   // The enable is combinational so a wake is never a cycle late.
   assign clk_enable = awake_reg || busy || (state_reg != ICWC_IDLE); // R05 R15
   assign bw_sel = bw_ovr_reg ? bw_val_reg : bw_for_gain(setting_in.gain); // R14
   assign cal_run = (state_reg == ICWC_CAL);
   assign cal_params_revert = revert_reg;
   assign setting_restore = restore_reg;
   assign setting_out = saved;
   assign reg_rdata = rdata_reg;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   property p_overload_awake;
      @(posedge core_clk) disable iff (!rst_n)
      wake_in.overload |-> clk_enable;
   endproperty
   a_overload_awake: assert property (p_overload_awake) // R04
      else $error("Clock gated during overload.");

   property p_keep_awake;
      @(posedge core_clk) disable iff (!rst_n)
      awake_reg |-> clk_enable;
   endproperty
   a_keep_awake: assert property (p_keep_awake) // R05
      else $error("Clock gated while keep-awake set.");

   property p_idle_gates;
      @(posedge core_clk) disable iff (!rst_n)
      (state_reg == ICWC_IDLE && !busy && !awake_reg) |-> !clk_enable;
   endproperty
   a_idle_gates: assert property (p_idle_gates) // R01
      else $error("Clock running with no work pending.");

   property p_button_wakes;
      @(posedge core_clk) disable iff (!rst_n)
      (wake_in.button || wake_in.link_active) |-> clk_enable;
   endproperty
   a_button_wakes: assert property (p_button_wakes) // R02
      else $error("Wake source did not enable clock.");

   property p_reply_runs;
      @(posedge core_clk) disable iff (!rst_n)
      (wake_in.reply_busy || wake_in.adjust_busy) |-> clk_enable;
   endproperty
   a_reply_runs: assert property (p_reply_runs) // R03
      else $error("Clock gated during pending task.");

   sequence s_cal_begin;
      cal_cmd && state_reg != ICWC_CAL;
   endsequence
   property p_cal_start;
      @(posedge core_clk) disable iff (!rst_n)
      s_cal_begin |=> cal_run;
   endproperty
   a_cal_start: assert property (p_cal_start) // R07
      else $error("Calibration command did not start calibration.");

   sequence s_cal_finish;
      cal_end;
   endsequence
   property p_cal_restore;
      @(posedge core_clk) disable iff (!rst_n)
      s_cal_finish |=> setting_restore && !bw_ovr_reg;
   endproperty
   a_cal_restore: assert property (p_cal_restore) // R09
      else $error("Setting or bandwidth not restored after calibration.");

   property p_cal_fail_err;
      @(posedge core_clk) disable iff (!rst_n)
      (cal_run && cal_fail) |=> dev_err_reg == 8'h01 && cal_params_revert;
   endproperty
   a_cal_fail_err: assert property (p_cal_fail_err) // R10
      else $error("Failed calibration did not record error.");

   property p_bw_button;
      @(posedge core_clk) disable iff (!rst_n)
      (wake_in.button && !wr_hit(`ICWC_REG_BW)) |=>
         bw_sel == bw_for_gain(setting_in.gain);
   endproperty
   a_bw_button: assert property (p_bw_button) // R12
      else $error("Button did not restore bandwidth.");

   property p_cal_bound;
      @(posedge core_clk) disable iff (!rst_n)
      cal_run |-> cal_cnt_reg < `ICWC_CAL_CNT_W'(`ICWC_CAL_CYCLES);
   endproperty
   a_cal_bound: assert property (p_cal_bound) // R08
      else $error("Calibration exceeded its time limit.");

endmodule : icwc_top

//--- testbench/icwc_cal_model.sv
// Behavioural calibration engine facing the block's calibration handshake.
// Assumes cal_run is a level from the block, synchronous to core_clk.
`timescale 1ns/100ps

module icwc_cal_model (
   // Clock and reset.
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Scenario controls.
   input  wire logic       fail_mode,
   input  wire logic [7:0] delay,
   // Calibration handshake.
   input  wire logic       cal_run,
   output logic            cal_done,
   output logic            cal_fail
);
   logic [7:0] cnt_reg;

   // One result pulse per run; the count parks past delay so it never repeats.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg  <= 8'h00;
         cal_done <= 1'b0;
         cal_fail <= 1'b0;
      end else begin
         cal_done <= 1'b0;
         cal_fail <= 1'b0;
         if (!cal_run) begin
            cnt_reg <= 8'h00;
         end else if (cnt_reg == delay) begin
            cal_done <= !fail_mode;
            cal_fail <= fail_mode;
            cnt_reg  <= cnt_reg + 8'h01;
         end else if (cnt_reg < delay) begin
            cnt_reg <= cnt_reg + 8'h01;
         end
      end
   end
endmodule : icwc_cal_model

//--- testbench/icwc_top_tb.sv
// Self-checking bench for the idle clock and wake control block.
// Assumes the calibration model answers well inside the timeout.
`timescale 1ns/100ps
`include "icwc_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end

module icwc_top_tb;
   import icwc_pkg::*;
   logic          core_clk = 1'b0;
   logic          rst_n;
   icwc_wake_s    wake_in;
   icwc_setting_s setting_in;
   logic          cal_done, cal_fail, cal_run, cal_params_revert;
   logic          setting_restore, clk_enable, irq;
   icwc_setting_s setting_out;
   logic [1:0]    bw_sel;
   logic [3:0]    reg_addr;
   logic [31:0]   reg_wdata, reg_rdata, d;
   logic          reg_wr, reg_rd, fail_mode;
   int            bad_count = 0;
   int            total_checks = 0;

   always #5 core_clk = ~core_clk;

   icwc_top u_icwc_top (.core_clk(core_clk), .rst_n(rst_n),
      .wake_in(wake_in), .setting_in(setting_in), .cal_done(cal_done),
      .cal_fail(cal_fail), .cal_run(cal_run),
      .cal_params_revert(cal_params_revert),
      .setting_restore(setting_restore), .setting_out(setting_out),
      .bw_sel(bw_sel), .clk_enable(clk_enable), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));

   icwc_cal_model u_icwc_cal_model (.core_clk(core_clk), .rst_n(rst_n),
      .fail_mode(fail_mode), .delay(8'd20), .cal_run(cal_run),
      .cal_done(cal_done), .cal_fail(cal_fail));

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask : reg_read

   task automatic press_button();
      @(posedge core_clk);
      wake_in.button <= 1'b1;
      @(posedge core_clk);
      wake_in.button <= 1'b0;
   endtask : press_button

   task automatic t_idle();
      tick(4);
      `CHK(clk_enable, 1'b0)
      reg_read(`ICWC_REG_CTRL, d);
      `CHK(d[0], 1'b0)
   endtask : t_idle

   // Each wake source held a while; the clock must run throughout.
   task automatic t_wake();
      int src[5] = '{5, 3, 2, 1, 0};
      for (int i = 0; i < 5; i++) begin
         @(posedge core_clk);
         wake_in[src[i]] <= 1'b1;
         for (int j = 0; j < 12; j++) begin
            tick(1);
            `CHK(clk_enable, 1'b1)
         end
         wake_in[src[i]] <= 1'b0;
         tick(4);
         `CHK(clk_enable, 1'b0)
      end
   endtask : t_wake

   task automatic t_awake();
      reg_write(`ICWC_REG_CTRL, 32'h1);
      tick(8);
      `CHK(clk_enable, 1'b1)
      reg_read(`ICWC_REG_STATUS, d);
      `CHK(d, 32'h0000_0004)
      reg_write(`ICWC_REG_CTRL, 32'h0);
      tick(4);
      `CHK(clk_enable, 1'b0)
   endtask : t_awake

   task automatic t_bw();
      logic [15:0] g[5] = '{16'h0032, 16'h01f4, 16'h1388, 16'h4e20, 16'hfe0c};
      logic [1:0]  e[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
      for (int i = 0; i < 5; i++) begin
         @(posedge core_clk);
         setting_in.gain <= g[i];
         tick(1);
         `CHK(bw_sel, e[i])
      end
      setting_in.gain <= 16'h0032;
      reg_write(`ICWC_REG_BW, 32'h3);
      tick(1);
      `CHK(bw_sel, 2'h3)
      reg_read(`ICWC_REG_BW, d);
      `CHK(d[1:0], 2'h3)
      press_button();
      tick(2);
      `CHK(bw_sel, 2'h0)
   endtask : t_bw

   // A mid-run power cycle drops keep-awake and any bandwidth override.
   task automatic t_reset();
      reg_write(`ICWC_REG_CTRL, 32'h1);
      reg_write(`ICWC_REG_BW, 32'h3);
      tick(1);
      `CHK(bw_sel, 2'h3)
      @(posedge core_clk);
      rst_n <= 1'b0;
      tick(2);
      `CHK(clk_enable, 1'b1)
      @(posedge core_clk);
      rst_n <= 1'b1;
      tick(2);
      `CHK(bw_sel, 2'h0)
      `CHK(clk_enable, 1'b0)
      reg_read(`ICWC_REG_CTRL, d);
      `CHK(d[0], 1'b0)
   endtask : t_reset

   // Gain and offset change mid-run; the saved pair must come back.
   task automatic t_cal(input logic fail, input logic by_buttons);
      int n;
      fail_mode = fail;
      setting_in <= {16'h0032, 16'h1234};
      reg_write(`ICWC_REG_BW, 32'h2);
      if (by_buttons) begin
         @(posedge core_clk);
         wake_in.cal_buttons <= 1'b1;
         @(posedge core_clk);
         wake_in.cal_buttons <= 1'b0;
      end else begin
         reg_write(`ICWC_REG_CTRL, 32'h2);
      end
      #1 `CHK(cal_run, 1'b1)
      setting_in <= {16'h4e20, 16'h0bad};
      tick(2);
      `CHK(clk_enable, 1'b1)
      for (n = 0; n < 60 && setting_restore !== 1'b1; n++) tick(1);
      `CHK(setting_restore, 1'b1)
      `CHK(setting_out, {16'h0032, 16'h1234})
      `CHK(cal_params_revert, fail)
      `CHK(cal_run, 1'b0)
      tick(1);
      `CHK(bw_sel, 2'h3)
      reg_read(`ICWC_REG_DEV_ERR, d);
      `CHK(d[7:0], fail ? 8'h01 : 8'h00)
   endtask : t_cal

   task automatic t_irq();
      reg_write(`ICWC_REG_IRQ_STAT, 32'hf);
      reg_write(`ICWC_REG_IRQ_MASK, 32'h1);
      tick(1);
      `CHK(irq, 1'b0)
      reg_read(`ICWC_REG_IRQ_MASK, d);
      `CHK(d, 32'h0000_0001)
      press_button();
      tick(2);
      `CHK(irq, 1'b1)
      reg_write(`ICWC_REG_IRQ_STAT, 32'h1);
      tick(1);
      `CHK(irq, 1'b0)
      reg_write(`ICWC_REG_IRQ_MASK, 32'h0);
      press_button();
      tick(2);
      `CHK(irq, 1'b0)
      reg_read(`ICWC_REG_IRQ_STAT, d);
      `CHK(d[0], 1'b1)
      reg_write(4'hf, 32'hffff_ffff);
      reg_read(4'hf, d);
      `CHK(d, 32'h0)
   endtask : t_irq

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   initial begin
      rst_n      = 1'b0;
      wake_in    = '0;
      setting_in = '0;
      reg_addr   = 4'h0;
      reg_wdata  = 32'h0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      fail_mode  = 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      t_idle();
      t_wake();
      t_awake();
      t_bw();
      t_reset();
      t_cal(1'b0, 1'b0);
      t_cal(1'b1, 1'b1);
      t_irq();
      results();
   end

   // The whole sequence needs a few hundred cycles at most.
   initial begin
      #200000;
      bad_count++;
      results();
   end
endmodule : icwc_top_tb
